/* File: core/pbc_pkg.sv */
// package for the basic phy control register block
// assumes a 16-bit management register port driven by the serial management logic
package pbc_pkg;
  localparam logic [4:0]  CTRL_REG_INDEX   = 5'h00;
  localparam int          BIT_SW_RESET     = 15;
  localparam int          BIT_LOOPBACK     = 14;
  localparam int          BIT_RATE_LOW     = 13;
  localparam int          BIT_NEG_ENABLE   = 12;
  localparam int          BIT_STANDBY      = 11;
  localparam int          BIT_ISOLATE      = 10;
  localparam int          BIT_NEG_RESTART  = 9;
  localparam int          BIT_FULL_DUPLEX  = 8;
  localparam int          BIT_COL_TEST     = 7;
  localparam int          BIT_RATE_HIGH    = 6;
  localparam int          BIT_ONE_WAY_TX   = 5;
  localparam logic [1:0]  RATE_100M        = 2'h1;
  localparam logic [3:0]  MODE_NORMAL_SEL  = 4'h3;
  localparam logic [3:0]  RESET_CYCLES     = 4'h8;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  index;
    logic [15:0] wdata;
  } pbc_req_type;
  typedef struct packed {
    logic loopback;
    logic standby;
    logic isolate;
    logic one_way_tx;
    logic go_normal;
    logic logic_reset;
  } pbc_ctrl_type;
endpackage : pbc_pkg

/* File: core/pbc_ctrl.sv */
// basic control register, index 0, of the phy management register set
// assumes requests come from the management interface logic on sys_clk_i
`timescale 1ns/1ps
// Function
// - rate field from bits 6 and 13; 01 means 100 Mbit/s, reset 01
// - rate codes other than 01 in a write are discarded; the other fields still take the write
// - negotiation enable and restart read 0, writes ignored
// - full duplex bit reads 1, writes ignored
// - collision test bit reads 0, writes ignored
// - standby request honoured only without isolation, else conflict event
// - clearing standby starts normal mode with a one-cycle go_normal pulse
// - isolation honoured only without standby, else conflict event
// - one-way transmit applies only with negotiation off and full duplex
// - one-way transmit set forwards data without link; resets to 0
module pbc_ctrl
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire pbc_pkg::pbc_req_type req_i,
  input  wire logic                 link_ok_i,
  output logic [15:0]               rdata_o,
  output logic                      conflict_o,
  output logic                      tx_allow_o,
  output pbc_pkg::pbc_ctrl_type     ctrl_o
);
  import pbc_pkg::*;

  logic        loopback_ff;
  logic        standby_ff;
  logic        isolate_ff;
  logic        one_way_ff;
  logic [1:0]  rate_ff;
  logic        go_normal_ff;
  logic        conflict_ff;
  logic [3:0]  rst_cnt_ff;
  logic        sw_rst_ff;
  logic [15:0] rdata_ff;
  logic        tx_allow_ff;
  logic        wr_hit;
  logic        wr_standby;
  logic        wr_isolate;
  logic        neg_off;
  logic        full_duplex;
  logic [15:0] reg_view;

  assign wr_hit      = req_i.wr && (req_i.index == CTRL_REG_INDEX) && !sw_rst_ff;
  assign wr_standby  = req_i.wdata[BIT_STANDBY];
  assign wr_isolate  = req_i.wdata[BIT_ISOLATE];
  assign neg_off     = 1'b0;
  assign full_duplex = 1'b1;

  // software reset, self-clearing after a fixed count
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sw_rst_ff  <= 1'b0;
      rst_cnt_ff <= 4'h0;
    end
    else if (wr_hit && req_i.wdata[BIT_SW_RESET])
    begin
      sw_rst_ff  <= 1'b1;
      rst_cnt_ff <= RESET_CYCLES;
    end
    else if (sw_rst_ff)
    begin
      rst_cnt_ff <= rst_cnt_ff - 4'h1;
      sw_rst_ff  <= (rst_cnt_ff != 4'h1);
    end
  end

  // writable control fields
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || sw_rst_ff)
    begin
      loopback_ff  <= 1'b0;
      one_way_ff   <= 1'b0;
      rate_ff      <= RATE_100M;
      standby_ff   <= 1'b0;
      isolate_ff   <= 1'b0;
      go_normal_ff <= 1'b0;
      conflict_ff  <= 1'b0;
    end
    else
    begin
      go_normal_ff <= 1'b0;
      conflict_ff  <= 1'b0;
      if (wr_hit)
      begin
        loopback_ff <= req_i.wdata[BIT_LOOPBACK];
        one_way_ff  <= req_i.wdata[BIT_ONE_WAY_TX];
        if ({req_i.wdata[BIT_RATE_HIGH], req_i.wdata[BIT_RATE_LOW]} == RATE_100M)
        begin
          rate_ff <= RATE_100M;
        end
        if (wr_standby && !standby_ff && (isolate_ff || wr_isolate))
        begin
          conflict_ff <= 1'b1;
        end
        else if (wr_standby)
        begin
          standby_ff <= 1'b1;
        end
        else
        begin
          standby_ff   <= 1'b0;
          go_normal_ff <= standby_ff;
        end
        if (wr_isolate && !isolate_ff && (standby_ff || wr_standby))
        begin
          conflict_ff <= 1'b1;
        end
        else
        begin
          isolate_ff <= wr_isolate;
        end
      end
    end
  end

  // read view; fixed bits and reserved bits
  always_comb
  begin
    reg_view                  = 16'h0000;
    reg_view[BIT_SW_RESET]    = sw_rst_ff;
    reg_view[BIT_LOOPBACK]    = loopback_ff;
    reg_view[BIT_RATE_LOW]    = rate_ff[0];
    reg_view[BIT_NEG_ENABLE]  = neg_off;
    reg_view[BIT_STANDBY]     = standby_ff;
    reg_view[BIT_ISOLATE]     = isolate_ff;
    reg_view[BIT_NEG_RESTART] = neg_off;
    reg_view[BIT_FULL_DUPLEX] = full_duplex;
    reg_view[BIT_COL_TEST]    = 1'b0;
    reg_view[BIT_RATE_HIGH]   = rate_ff[1];
    reg_view[BIT_ONE_WAY_TX]  = one_way_ff;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rdata_ff <= 16'h0000;
    end
    else if (req_i.rd && (req_i.index == CTRL_REG_INDEX))
    begin
      rdata_ff <= reg_view;
    end
  end

  // transmit gating from link_ok_i or the one-way enable
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_allow_ff <= 1'b0;
    end
    else
    begin
      tx_allow_ff <= link_ok_i || (one_way_ff && !neg_off && full_duplex);
    end
  end

  assign rdata_o               = rdata_ff;
  assign conflict_o            = conflict_ff;
  assign tx_allow_o            = tx_allow_ff;
  assign ctrl_o.loopback       = loopback_ff;
  assign ctrl_o.standby        = standby_ff;
  assign ctrl_o.isolate        = isolate_ff;
  assign ctrl_o.one_way_tx     = one_way_ff;
  assign ctrl_o.go_normal      = go_normal_ff;
  assign ctrl_o.logic_reset    = sw_rst_ff;

  // register behaviour checks
  chk_rate_fixed: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rate_ff == RATE_100M) else $error("rate field left 100M code");
  chk_rate_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i.rd && req_i.index == CTRL_REG_INDEX) |=>
    (rdata_o[BIT_RATE_HIGH] == RATE_100M[1] && rdata_o[BIT_RATE_LOW] == RATE_100M[0]))
    else $error("rate field reads wrong code");
  chk_fixed_bits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i.rd && req_i.index == CTRL_REG_INDEX) |=> (rdata_o[12] == 1'b0 && rdata_o[9] == 1'b0))
    else $error("negotiation bits read nonzero");
  chk_duplex_one: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i.rd && req_i.index == CTRL_REG_INDEX) |=> (rdata_o[8] && !rdata_o[7] && rdata_o[4:0] == 5'h00))
    else $error("duplex or collision bit wrong");
  chk_col_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i.rd && req_i.index == CTRL_REG_INDEX) |=> !rdata_o[7]) else $error("collision bit set");
  chk_not_both: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(standby_ff && isolate_ff)) else $error("standby and isolate both set");
  chk_standby_take: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_hit && wr_standby && !isolate_ff && !wr_isolate) |=> ctrl_o.standby) else $error("standby request lost");
  chk_conflict_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i || sw_rst_ff)
    (wr_hit && wr_standby && !standby_ff && isolate_ff) |=> (conflict_o && !standby_ff))
    else $error("standby conflict not flagged");
  chk_go_normal: assert property (@(posedge sys_clk_i) disable iff (rst_i || sw_rst_ff)
    (wr_hit && !wr_standby && standby_ff) |=> ctrl_o.go_normal) else $error("normal start missing");
  chk_iso_take: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_hit && wr_isolate && !standby_ff && !wr_standby) |=> ctrl_o.isolate) else $error("isolate request lost");
  chk_iso_conflict: assert property (@(posedge sys_clk_i) disable iff (rst_i || sw_rst_ff)
    (wr_hit && wr_isolate && !isolate_ff && standby_ff) |=> (conflict_o && !isolate_ff))
    else $error("isolate conflict not flagged");
  chk_tx_link: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    link_ok_i |=> tx_allow_o) else $error("transmit blocked with valid link");
  chk_tx_blocked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!link_ok_i && !one_way_ff) |=> !tx_allow_o) else $error("transmit allowed without link");
  chk_one_way_tx: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (one_way_ff && !sw_rst_ff) |=> tx_allow_o) else $error("one-way transmit not allowed");
  chk_one_way_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit |=> (ctrl_o.one_way_tx == $past(req_i.wdata[BIT_ONE_WAY_TX])))
    else $error("one-way enable not stored");
  chk_reset_busy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(sw_rst_ff) |-> sw_rst_ff[*8]) else $error("reset bit dropped early");
  chk_reset_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(sw_rst_ff) |-> ##8 !sw_rst_ff) else $error("reset bit did not self-clear");
  chk_reset_defaults: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sw_rst_ff |=> (!loopback_ff && !standby_ff && !isolate_ff && !one_way_ff))
    else $error("fields not cleared by reset bit");
  chk_loopback_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit |=> (ctrl_o.loopback == $past(req_i.wdata[BIT_LOOPBACK])))
    else $error("loopback bit not stored");
endmodule : pbc_ctrl

/* File: tb/pbc_host.sv */
// management host model issuing register requests
// assumes requests are taken on the edge after they are raised
`timescale 1ns/1ps
module pbc_host
(
  input  wire logic            sys_clk_i,
  output pbc_pkg::pbc_req_type req_o
);
  import pbc_pkg::*;
  initial req_o = '{wr: 1'b0, rd: 1'b0, index: CTRL_REG_INDEX, wdata: 16'h0000};
  task automatic wr(input logic [15:0] d);
    @(posedge sys_clk_i);
    #1;
    req_o.wdata = {d[15:5], 5'h00};
    req_o.wr    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    req_o.wr    = 1'b0;
    req_o.wdata = ~req_o.wdata;
  endtask : wr
  task automatic rd;
    @(posedge sys_clk_i);
    #1;
    req_o.rd = 1'b1;
    @(posedge sys_clk_i);
    #1;
    req_o.rd = 1'b0;
  endtask : rd
endmodule : pbc_host

/* File: tb/tb.sv */
// self-checking bench for the basic control register
// assumes pbc_host drives all requests
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb;
  import pbc_pkg::*;
  logic         sys_clk_i = 1'b0;
  logic         rst_i     = 1'b1;
  logic         link_ok_i = 1'b0;
  pbc_req_type  req;
  logic [15:0]  rdata_o;
  logic         conflict_o;
  logic         tx_allow_o;
  pbc_ctrl_type ctrl_o;
  int           err_count = 0;
  int           compares  = 0;
  int           cycles    = 0;
  int           seed      = 32'h0577cb47;
  logic [15:0]  w;
  logic [15:0]  fixed [4] = '{16'h0040, 16'h1280, 16'h2340, 16'h3280};
  logic         lb, sb, iso, ow, cf, gn;
  always #2 sys_clk_i = ~sys_clk_i;
  pbc_host u_pbc_host (.sys_clk_i(sys_clk_i), .req_o(req));
  pbc_ctrl u_pbc_ctrl (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .link_ok_i(link_ok_i),
    .rdata_o(rdata_o), .conflict_o(conflict_o), .tx_allow_o(tx_allow_o), .ctrl_o(ctrl_o));
  function automatic logic [15:0] view(input logic l, s, i, o);
    return {1'b0, l, 2'b10, s, i, 2'b01, 2'b00, o, 5'h00};
  endfunction : view
  task automatic check_view;
    u_pbc_host.rd();
    `CHK(rdata_o & 16'hffe0, view(lb, sb, iso, ow))
  endtask : check_view
  task automatic wrap_up;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    {lb, sb, iso, ow} = 4'h0;
    `CHK(rdata_o, 16'h0000)
    check_view();
    foreach (fixed[k])
    begin
      u_pbc_host.wr(fixed[k]);
      check_view();
    end
    repeat (60)
    begin
      w = (16'($random(seed)) & 16'h5fa0) | 16'h2000;
      link_ok_i = 1'($random(seed));
      cf = (w[11] & !sb & (iso | w[10])) | (w[10] & !iso & sb);
      gn = sb & !w[11];
      {sb, iso} = {w[11] & !(!sb & (iso | w[10])), w[10] & !(!iso & (sb | w[11]))};
      lb = w[14];
      ow = w[5];
      u_pbc_host.wr(w);
      `CHK({conflict_o, ctrl_o.go_normal}, {cf, gn})
      `CHK({ctrl_o.loopback, ctrl_o.standby, ctrl_o.isolate, ctrl_o.one_way_tx}, {lb, sb, iso, ow})
      check_view();
      `CHK(tx_allow_o, link_ok_i | ow)
    end
    u_pbc_host.wr(16'ha000);
    u_pbc_host.wr(16'h6020);
    u_pbc_host.rd();
    `CHK({rdata_o[15], ctrl_o.logic_reset}, 2'b11)
    repeat (10) @(posedge sys_clk_i);
    {lb, sb, iso, ow} = 4'h0;
    check_view();
    `CHK(ctrl_o, pbc_ctrl_type'(6'h00))
    wrap_up();
  end
endmodule : tb
